/* File: hdl/clock_multiplier_control_pkg.sv */
package clock_multiplier_control_pkg;
   localparam int          ADDR_W         = 12;
   localparam logic [9:0]  CTRL_IDX       = 10'h097;
   localparam logic [9:0]  STAT_IDX       = 10'h098;
   localparam logic [9:0]  CLR_IDX        = 10'h099;
   localparam logic [9:0]  IEN_IDX        = 10'h09a;
   localparam logic [11:0] CTRL_ADDR      = {CTRL_IDX, 2'b00};
   localparam logic [11:0] STAT_ADDR      = {STAT_IDX, 2'b00};
   localparam logic [11:0] CLR_ADDR       = {CLR_IDX, 2'b00};
   localparam logic [11:0] IEN_ADDR       = {IEN_IDX, 2'b00};
   localparam logic [7:0]  CTRL_RESET     = 8'h00;
   localparam int          EN_BIT         = 7;
   localparam int          INIT_BIT       = 6;
   localparam int          RDY_BIT        = 5;
   localparam int          DIV_LSB        = 2;
   localparam int          SEL_LSB        = 0;
   localparam int          SEL_EXT_BIT    = 0;
   localparam int          SEL_X4_BIT     = 1;
   localparam int          EV_LOCK        = 0;
   localparam int          EV_UNLOCK      = 1;
   localparam int          EV_W           = 2;
   localparam logic [2:0]  DIV_UNITY      = 3'h2;
   localparam logic [2:0]  DIV_CODE_LO    = 3'h2;
   localparam logic [2:0]  DIV_CODE_HI    = 3'h6;
   localparam logic [3:0]  BURST_LEN      = 4'h4;
   localparam logic [3:0]  ACC_STEP       = 4'h2;
   localparam int          LOCK_EDGES_DEF = 16;

   typedef enum logic [3:0] {
      ST_OFF     = 4'b0001,
      ST_ARMED   = 4'b0010,
      ST_LOCKING = 4'b0100,
      ST_LOCKED  = 4'b1000
   } mode_t;
endpackage

/* File: hdl/sync2.sv */
`timescale 1ns/100ps
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;

   sync_t r;
   sync_t n;

   always_comb begin
      n    = r;
      n.s1 = d;
      n.s2 = r.s1;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign q = r.s2;
endmodule

/* File: hdl/clk_burst_scaler.sv */
`timescale 1ns/100ps
module clk_burst_scaler
   import clock_multiplier_control_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       run,
   input  wire logic       in_edge,
   input  wire logic [2:0] divisor,
   output logic            tick,
   output logic            idle
);
   typedef struct packed {
      logic [3:0] left;
      logic [2:0] acc;
      logic       tick;
   } burst_t;

   burst_t     r;
   burst_t     n;
   logic [3:0] sum;
   logic [3:0] dec;

   always_comb begin
      n      = r;
      n.tick = 1'b0;
      sum    = {1'b0, r.acc} + ACC_STEP;
      dec    = r.left;
      if (!run) begin
         n.left = '0;
         n.acc  = '0;
      end else begin
         // each fast pulse adds two credits; a tick costs divisor credits
         if (r.left != 4'h0) begin
            dec = r.left - 4'h1;
            if (sum >= {1'b0, divisor}) begin
               n.acc  = 3'(sum - {1'b0, divisor});
               n.tick = 1'b1;
            end else begin
               n.acc = sum[2:0];
            end
         end
         n.left = dec;
         // four fast pulses per input edge, then silence; saturates if edges crowd in
         if (in_edge) begin
            n.left = (dec > 4'hb) ? 4'hf : dec + BURST_LEN;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign tick = r.tick;
   assign idle = (r.left == 4'h0);
endmodule

/* File: hdl/clock_multiplier_ctrl.sv */
// Local design decision: the AHB-Lite register port.
`timescale 1ns/100ps
module clock_multiplier_ctrl
   import clock_multiplier_control_pkg::*;
#(
   parameter int LOCK_EDGES = LOCK_EDGES_DEF
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   input  wire logic        int_osc,
   input  wire logic        ext_osc,
   output logic             mult_tick,
   output logic             mult_lock,
   output logic             irq
);
   typedef struct packed {
      logic              en;
      logic              init;
      logic [2:0]        div;
      logic [1:0]        sel;
      mode_t             st;
      logic [7:0]        cnt;
      logic              osc_q;
      logic              half;
      logic [EV_W-1:0]   stat;
      logic [EV_W-1:0]   ien;
      logic              irq;
      logic              dph;
      logic              dwr;
      logic [ADDR_W-1:0] dad;
      logic [7:0]        rd;
   } state_t;

   state_t          r;
   state_t          n;
   logic [1:0]      osc_s;
   logic            osc_sel;
   logic            osc_rise;
   logic            in_edge;
   logic            init_go;
   logic            sel_chg;
   logic            a_ok;
   logic            burst_idle;
   logic [2:0]      div_n;
   logic [EV_W-1:0] ev;
   logic [EV_W-1:0] clr;

   // hsize is ignored: only whole-word transfers reach this slave
   sync2 #(
      .W (2)
   ) u_osc_sync (
      .clk (clk),
      .rst (rst),
      .d   ({ext_osc, int_osc}),
      .q   (osc_s)
   );

   function automatic logic [2:0] scale_div(input logic [1:0] sel,
                                            input logic [2:0] code);
      logic [2:0] d;
      d = DIV_UNITY;
      if (sel[SEL_X4_BIT] && code >= DIV_CODE_LO && code <= DIV_CODE_HI) begin
         d = code + 3'h1;
      end
      return d;
   endfunction

   // x2 bases force unity scaling; 000, 001 and reserved 111 give factor one
   assign div_n = scale_div(r.sel, r.div);

   // source pick; the x2 bases halve the oscillator before the x4 stage
   assign osc_sel  = r.sel[SEL_EXT_BIT] ? osc_s[1] : osc_s[0];
   assign osc_rise = osc_sel & ~r.osc_q;
   assign in_edge  = r.sel[SEL_X4_BIT] ? osc_rise : (osc_rise & ~r.half);

   assign a_ok = (haddr[31:ADDR_W] == '0);

   always_comb begin
      n       = r;
      ev      = '0;
      clr     = '0;
      init_go = 1'b0;
      sel_chg = 1'b0;
      n.osc_q = osc_sel;
      if (osc_rise) begin
         n.half = ~r.half;
      end

      // data phase of a write
      if (r.dph && r.dwr) begin
         if (r.dad == CTRL_ADDR) begin
            n.en    = hwdata[EN_BIT];
            n.init  = hwdata[INIT_BIT];
            n.div   = hwdata[DIV_LSB+:3];
            n.sel   = hwdata[SEL_LSB+:2];
            // initialize only counts once the block was already enabled
            init_go = hwdata[INIT_BIT] && hwdata[EN_BIT] && r.en;
            sel_chg = (hwdata[SEL_LSB+:2] != r.sel);
         end else if (r.dad == CLR_ADDR) begin
            clr = hwdata[EV_W-1:0];
         end else if (r.dad == IEN_ADDR) begin
            n.ien = hwdata[EV_W-1:0];
         end
      end

      case (r.st)
         ST_OFF: begin
            if (n.en) begin
               n.st = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (init_go) begin
               n.st  = ST_LOCKING;
               n.cnt = '0;
            end
         end
         ST_LOCKING: begin
            if (in_edge) begin
               if (r.cnt == 8'(LOCK_EDGES - 1)) begin
                  n.st         = ST_LOCKED;
                  ev[EV_LOCK]  = 1'b1;
               end else begin
                  n.cnt = r.cnt + 8'h01;
               end
            end
         end
         ST_LOCKED: begin
            n.st = ST_LOCKED;
         end
         default: begin
            n.st = ST_OFF;
         end
      endcase

      // clearing enable drops the lock state and the edge count; a new source must relock
      if (!n.en) begin
         n.st  = ST_OFF;
         n.cnt = '0;
      end else if (sel_chg && r.st != ST_OFF) begin
         n.st = ST_ARMED;
      end
      if (r.st == ST_LOCKED && n.st != ST_LOCKED) begin
         ev[EV_UNLOCK] = 1'b1;
      end

      // set wins over clear in the same cycle
      n.stat = (r.stat & ~clr) | ev;
      n.irq  = |(n.stat & n.ien);

      // address phase; read data come from the post-write state
      n.dph = hsel && hready && htrans[1];
      n.dwr = hwrite;
      n.dad = a_ok ? haddr[ADDR_W-1:0] : '1;
      n.rd  = '0;
      if (n.dph && !hwrite && a_ok) begin
         if (haddr[ADDR_W-1:0] == CTRL_ADDR) begin
            n.rd[EN_BIT]        = n.en;
            n.rd[INIT_BIT]      = n.init & ~n.en;
            n.rd[RDY_BIT]       = (n.st == ST_LOCKED);
            n.rd[DIV_LSB+:3]    = n.div;
            n.rd[SEL_LSB+:2]    = n.sel;
         end else if (haddr[ADDR_W-1:0] == STAT_ADDR) begin
            n.rd[EV_W-1:0] = n.stat;
         end else if (haddr[ADDR_W-1:0] == IEN_ADDR) begin
            n.rd[EV_W-1:0] = n.ien;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r       <= '0;
         r.en    <= CTRL_RESET[EN_BIT];
         r.init  <= CTRL_RESET[INIT_BIT];
         r.div   <= CTRL_RESET[DIV_LSB+:3];
         r.sel   <= CTRL_RESET[SEL_LSB+:2];
         r.st    <= ST_OFF;
      end else begin
         r <= n;
      end
   end

   // ticks run only while locked, so the output is stable when seen
   clk_burst_scaler u_burst (
      .clk     (clk),
      .rst     (rst),
      .run     (r.st == ST_LOCKED),
      .in_edge (in_edge),
      .divisor (div_n),
      .tick    (mult_tick),
      .idle    (burst_idle)
   );

   assign mult_lock = (r.st == ST_LOCKED);
   assign irq       = r.irq;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = {24'h000000, r.rd};

   property p_quiet_unlocked;
      @(posedge clk) disable iff (rst)
         (r.st != ST_LOCKED) |=> ##1 !mult_tick;
   endproperty

   a_tick_only_locked: assert property (p_quiet_unlocked)
      else $error("tick while not locked");

   a_burst_four_ticks: assert property (
      @(posedge clk) disable iff (rst)
         (mult_lock && in_edge && burst_idle && div_n == DIV_UNITY)
         |=> ##1 (mult_tick || !mult_lock)[*4])
      else $error("burst of four ticks missing");

   a_init_reads_zero: assert property (
      @(posedge clk) disable iff (rst)
         (n.dph && !hwrite && a_ok && haddr[ADDR_W-1:0] == CTRL_ADDR && n.en)
         |=> !hrdata[INIT_BIT])
      else $error("initialize bit read as one while enabled");

   a_ready_bit_read: assert property (
      @(posedge clk) disable iff (rst)
         (n.dph && !hwrite && a_ok && haddr[ADDR_W-1:0] == CTRL_ADDR)
         |=> hrdata[RDY_BIT] == mult_lock)
      else $error("ready bit disagrees with lock");

   a_lock_after_init: assert property (
      @(posedge clk) disable iff (rst)
         $rose(mult_lock) |-> $past(r.st == ST_LOCKING) && $past(in_edge))
      else $error("lock without initialization");

   a_disable_unlocks: assert property (
      @(posedge clk) disable iff (rst)
         (r.dph && r.dwr && r.dad == CTRL_ADDR && !hwdata[EN_BIT])
         |=> !mult_lock ##1 !mult_lock)
      else $error("still locked after disable");

   a_x2_ignores_scale: assert property (
      @(posedge clk) disable iff (rst)
         !r.sel[SEL_X4_BIT] |-> div_n == DIV_UNITY)
      else $error("scaling applied to a x2 base");

   a_scale_map: assert property (
      @(posedge clk) disable iff (rst)
         (r.sel[SEL_X4_BIT] && r.div >= DIV_CODE_LO && r.div <= DIV_CODE_HI)
         |-> div_n == r.div + 3'h1)
      else $error("wrong scale divisor");

   a_scale_unity: assert property (
      @(posedge clk) disable iff (rst)
         (r.div == 3'h0 || r.div == 3'h1) |-> div_n == DIV_UNITY)
      else $error("codes 000 and 001 not unity");

   a_x4_every_edge: assert property (
      @(posedge clk) disable iff (rst)
         (r.sel[SEL_X4_BIT] && osc_rise) |-> in_edge)
      else $error("x4 base missed an edge");

   a_x2_halves: assert property (
      @(posedge clk) disable iff (rst)
         (!r.sel[SEL_X4_BIT] && osc_rise && r.half) |-> !in_edge)
      else $error("x2 base did not halve");

   a_scale_reserved: assert property (
      @(posedge clk) disable iff (rst)
         (r.sel[SEL_X4_BIT] && r.div == 3'h7) |-> div_n == DIV_UNITY)
      else $error("reserved scale code not unity");

   a_lock_sets_status: assert property (
      @(posedge clk) disable iff (rst)
         $rose(mult_lock) |-> r.stat[EV_LOCK])
      else $error("lock gained without status event");

   a_unlock_sets_status: assert property (
      @(posedge clk) disable iff (rst)
         $fell(mult_lock) |-> r.stat[EV_UNLOCK])
      else $error("lock lost without status event");

   a_clear_drops_status: assert property (
      @(posedge clk) disable iff (rst)
         (r.dph && r.dwr && r.dad == CLR_ADDR && hwdata[EV_LOCK] && !ev[EV_LOCK])
         |=> !r.stat[EV_LOCK])
      else $error("status bit survived its clear");

   a_locking_needs_enable: assert property (
      @(posedge clk) disable iff (rst)
         (r.st == ST_LOCKING) |-> r.en)
      else $error("locking while disabled");

   a_off_when_disabled: assert property (
      @(posedge clk) disable iff (rst)
         !r.en |-> (r.st == ST_OFF && r.cnt == 8'h00))
      else $error("state kept while disabled");

   a_irq_level: assert property (
      @(posedge clk) disable iff (rst)
         irq == (|(r.stat & r.ien)))
      else $error("interrupt disagrees with enabled status");

   a_rdata_idle_zero: assert property (
      @(posedge clk) disable iff (rst)
         !(r.dph && !r.dwr) |-> hrdata == 32'h0)
      else $error("read data outside a read data phase");

   c_lock_seen: cover property (
      @(posedge clk) disable iff (rst) $rose(mult_lock));

   c_tick_burst: cover property (
      @(posedge clk) disable iff (rst) mult_tick ##1 mult_tick);

   c_unlock_irq: cover property (
      @(posedge clk) disable iff (rst) $rose(r.stat[EV_UNLOCK]) ##1 irq);

   c_scaled_ticks: cover property (
      @(posedge clk) disable iff (rst) mult_tick && div_n != DIV_UNITY);

   c_lock_dropped: cover property (
      @(posedge clk) disable iff (rst) $fell(mult_lock));
endmodule

/* File: verif/osc_model.sv */
`timescale 1ns/100ps
module osc_model #(
   parameter real INT_HALF = 400.0,
   parameter real EXT_HALF = 600.0
) (
   input  wire logic ext_on,
   output logic      int_osc,
   output logic      ext_osc
);
   // internal source runs free from power-up
   initial begin
      int_osc = 1'b0;
      #3;
      forever #(INT_HALF) int_osc = ~int_osc;
   end
   // external source stands low until enabled, then runs clean, so it is stable before init
   initial begin
      ext_osc = 1'b0;
      #7;
      forever #(EXT_HALF) ext_osc = ext_on ? ~ext_osc : 1'b0;
   end
endmodule

/* File: verif/tb.sv */
`timescale 1ns/100ps
module tb;
   import clock_multiplier_control_pkg::*;
   localparam int WIN = 840;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic        ext_on = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rd;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [1:0]  sel;
   logic [2:0]  sc;
   logic [11:0] regs [4] = '{CTRL_ADDR, STAT_ADDR, IEN_ADDR, 12'h000};
   wire logic   hreadyout, hresp, mult_tick, mult_lock, irq, int_osc, ext_osc;
   wire logic [31:0] hrdata;
   int          n_mismatch = 0;
   int          checks = 0;
   int          tick_n = 0;
   int          run = 0;
   int          maxrun = 0;
   int          n, edge_cyc, exp_n, tol;

   always #20 clk = ~clk;

   clock_multiplier_ctrl #(.LOCK_EDGES(2)) u_dut (
      .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .int_osc(int_osc),
      .ext_osc(ext_osc), .mult_tick(mult_tick), .mult_lock(mult_lock), .irq(irq));

   osc_model u_osc (.ext_on(ext_on), .int_osc(int_osc), .ext_osc(ext_osc));

   // tick count and longest run of back-to-back ticks
   always @(posedge clk) begin
      if (mult_tick === 1'b1) begin
         tick_n++;
         run++;
      end else begin
         run = 0;
      end
      if (run > maxrun) maxrun = run;
   end

   task automatic complete_run();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic chk_rng(input string name, input int lo, input int hi, input int seen);
      checks++;
      if (seen < lo || seen > hi) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, seen);
      end
   endtask

   // no wait-state count is assumed; the bound only catches a hung slave
   task automatic wait_rdy();
      int i;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (hreadyout !== 1'b1 && i < 64);
      if (hreadyout !== 1'b1) begin
         n_mismatch++;
         complete_run();
      end
   endtask

   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
      haddr  <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      hsel   <= 1'b1;
      wait_rdy();
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask

   task automatic settle(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   task automatic lock_cfg(input logic [7:0] cfg);
      int i;
      bus(CTRL_ADDR, 1'b1, 32'h0);
      bus(CTRL_ADDR, 1'b1, {24'h0, cfg});
      bus(CTRL_ADDR, 1'b1, {24'h0, cfg | 8'h80});
      bus(CTRL_ADDR, 1'b0, 32'h0);
      chk("ctrl enabled", {24'h0, cfg | 8'h80}, rd);
      repeat (130) @(posedge clk);
      bus(CTRL_ADDR, 1'b1, {24'h0, cfg | 8'hc0});
      i = 0;
      do begin
         bus(CTRL_ADDR, 1'b0, 32'h0);
         i++;
      end while (rd[RDY_BIT] !== 1'b1 && i < 100);
      chk("ctrl locked", {24'h0, cfg | 8'ha0}, rd);
      settle(1);
      chk("mult_lock", 32'h1, {31'h0, mult_lock});
   endtask

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (regs[k]) begin
         bus(regs[k], 1'b0, 32'h0);
         chk("reset read", 32'h0, rd);
      end
      chk("idle outputs", 32'h0, {29'h0, hresp, mult_lock, irq});
      bus(12'h000, 1'b1, 32'hff);
      bus(12'h000, 1'b0, 32'h0);
      chk("unmapped read", 32'h0, rd);
      bus(CTRL_ADDR, 1'b1, 32'h20);
      bus(CTRL_ADDR, 1'b0, 32'h0);
      chk("ready bit read-only", 32'h0, rd);
      ext_on <= 1'b1;
      bus(IEN_ADDR, 1'b1, 32'h3);
      bus(IEN_ADDR, 1'b0, 32'h0);
      chk("irq enable", 32'h3, rd);
      // every scale code on ext x4, then the other three sources
      for (int k = 0; k < 11; k++) begin
         sel = (k < 8) ? 2'h3 : 2'(k - 8);
         sc  = (k < 8) ? 3'(k) : 3'h6;
         lock_cfg({3'h0, sc, sel});
         n = (!sel[1] || sc < 3'h2 || sc == 3'h7) ? 2 : int'(sc) + 1;
         edge_cyc = (sel[0] ? 30 : 20) * (sel[1] ? 1 : 2);
         exp_n = WIN * 8 / (edge_cyc * n);
         tol = 8 / n + 2;
         tick_n = 0;
         maxrun = 0;
         settle(WIN);
         chk_rng("ticks", exp_n - tol, exp_n + tol, tick_n);
         if (n == 2) chk("burst length", 32'h4, maxrun);
      end
      bus(STAT_ADDR, 1'b0, 32'h0);
      chk("status events", 32'h3, rd);
      settle(1);
      chk("irq raised", 32'h1, {31'h0, irq});
      bus(CLR_ADDR, 1'b1, 32'h3);
      settle(2);
      chk("irq cleared", 32'h0, {31'h0, irq});
      bus(IEN_ADDR, 1'b1, 32'h0);
      bus(CTRL_ADDR, 1'b1, 32'h0f);
      settle(2);
      chk("lock after disable", 32'h0, {31'h0, mult_lock});
      tick_n = 0;
      settle(200);
      chk("ticks while off", 32'h0, tick_n);
      bus(STAT_ADDR, 1'b0, 32'h0);
      chk("lock lost", 32'h2, rd);
      chk("irq masked", 32'h0, {31'h0, irq});
      bus(IEN_ADDR, 1'b1, 32'h2);
      settle(2);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      bus(CLR_ADDR, 1'b1, 32'h2);
      settle(2);
      chk("irq after clear", 32'h0, {31'h0, irq});
      complete_run();
   end
endmodule
